// >>> embs_pkg.sv
// shared constants for the external memory bus strobe block
package embs_pkg;
    localparam int          ADDR_W         = 16;
    localparam int          DATA_W         = 16;
    localparam int          WAIT_W         = 3;
    // space codes of an external access
    localparam logic [1:0]  SPACE_PROG     = 2'h0;
    localparam logic [1:0]  SPACE_DATA     = 2'h1;
    localparam logic [1:0]  SPACE_IO       = 2'h2;
    // i/o address of the wait-state configuration register
    localparam logic [15:0] WSCFG_ADDR     = 16'hFFFF;
    // field positions inside the configuration word
    localparam int          LOW_PROG_POS   = 0;
    localparam int          HIGH_PROG_POS  = 3;
    localparam int          DATA_POS       = 6;
    localparam int          IO_POS         = 9;
    // all fields at maximum wait after reset, safe for slow parts
    localparam logic [15:0] WSCFG_RESET    = 16'h0FFF;
    // address bit that splits lower and upper program space
    localparam int          PROG_SPLIT_BIT = 15;

    typedef enum logic [3:0] {
        EMBS_IDLE   = 4'b0001,
        EMBS_WAIT   = 4'b0010,
        EMBS_READY  = 4'b0100,
        EMBS_FINISH = 4'b1000
    } embs_state_type;
endpackage

// >>> embs_wait_counter.sv
// down counter for generated wait states
`timescale 1ns/1ps
module embs_wait_counter #(
    parameter int WIDTH = 3
) (
    input  wire logic             mclk,
    input  wire logic             reset,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] load_value,
    output logic                  done
);
    logic [WIDTH-1:0] count_r;

    always_ff @(posedge mclk) begin
        if (reset) begin
            count_r <= '0;
        end else if (load) begin
            count_r <= load_value;
        end else if (count_r != '0) begin
            count_r <= count_r - WIDTH'(1);
        end
    end

    assign done = (count_r == '0) && !load;
endmodule

// >>> embs_bus_ctrl.sv
// external bus strobe control with wait-state generator
// Contract
// - read strobe asserted for every external read, drives output enable
// - write enable asserted for every external write
// - access strobe held for the whole external access
// - direction output shows read or write of current transfer
// - ready low: wait one cycle, sample ready again
// - stall access and processing until ready sampled high
// - each wait state lasts exactly one clock cycle
// - generator inserts software-set waits per program, data, i/o space
// - configuration register lives in i/o space, steers generator
// - low program field below 8000h, high field from 8000h
// - program select asserted for external program accesses
`timescale 1ns/1ps
module embs_bus_ctrl
    import embs_pkg::*;
#(
    parameter int WAIT_BITS = embs_pkg::WAIT_W
) (
    input  wire logic                      mclk,
    input  wire logic                      reset,
    input  wire logic                      req_valid,
    input  wire logic                      req_write,
    input  wire logic [1:0]                req_space,
    input  wire logic [embs_pkg::ADDR_W-1:0] req_addr,
    input  wire logic [embs_pkg::DATA_W-1:0] req_wdata,
    output logic                           req_ready,
    output logic                           rsp_valid,
    output logic [embs_pkg::DATA_W-1:0]    rsp_rdata,
    output logic                           cpu_stall,
    output logic [embs_pkg::ADDR_W-1:0]    ext_addr,
    output logic [embs_pkg::DATA_W-1:0]    ext_data_out,
    output logic                           ext_data_oe,
    input  wire logic [embs_pkg::DATA_W-1:0] ext_data_in,
    output logic                           read_strobe_n,
    output logic                           write_enable_n,
    output logic                           access_active_strobe_n,
    output logic                           read_not_write,
    output logic                           program_space_select_n,
    output logic                           data_space_select_n,
    output logic                           io_space_select_n,
    input  wire logic                      ready,
    output logic [embs_pkg::DATA_W-1:0]    wait_state_config
);
    import embs_pkg::*;

    embs_state_type                 state_r;
    embs_state_type                 state_nxt;
    logic [15:0]                    wait_state_config_reg_r;
    logic                           write_r;
    logic [1:0]                     space_r;
    logic [ADDR_W-1:0]              addr_r;
    logic [DATA_W-1:0]              wdata_r;
    logic [DATA_W-1:0]              rdata_r;
    logic                           rsp_r;
    logic [WAIT_BITS-1:0]           wait_sel;
    logic                           wait_done;
    logic                           cfg_hit;
    logic                           start;

    // a config write is internal: no external cycle happens for it
    assign cfg_hit = req_valid && req_write && (req_space == SPACE_IO) && (req_addr == WSCFG_ADDR);
    assign start   = req_valid && (state_r == EMBS_IDLE) && !cfg_hit;

    always_comb begin
        case (req_space)
            SPACE_PROG: begin
                if (req_addr[PROG_SPLIT_BIT]) begin
                    wait_sel = wait_state_config_reg_r[HIGH_PROG_POS +: WAIT_BITS];
                end else begin
                    wait_sel = wait_state_config_reg_r[LOW_PROG_POS +: WAIT_BITS];
                end
            end
            SPACE_DATA: begin
                wait_sel = wait_state_config_reg_r[DATA_POS +: WAIT_BITS];
            end
            default: begin
                wait_sel = wait_state_config_reg_r[IO_POS +: WAIT_BITS];
            end
        endcase
    end

    embs_wait_counter #(
        .WIDTH (WAIT_BITS)
    ) u_wait (
        .mclk       (mclk),
        .reset      (reset),
        .load       (start),
        .load_value (wait_sel),
        .done       (wait_done)
    );

    always_ff @(posedge mclk) begin
        if (reset) begin
            wait_state_config_reg_r <= WSCFG_RESET;
        end else if (cfg_hit && state_r == EMBS_IDLE) begin
            wait_state_config_reg_r <= req_wdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            write_r <= 1'b0;
            space_r <= SPACE_PROG;
            addr_r  <= '0;
            wdata_r <= '0;
        end else if (start) begin
            write_r <= req_write;
            space_r <= req_space;
            addr_r  <= req_addr;
            wdata_r <= req_wdata;
        end
    end

    // ready sampled each cycle after generated waits
    always_comb begin
        case (state_r)
            EMBS_IDLE: begin
                state_nxt = start ? EMBS_WAIT : EMBS_IDLE;
            end
            EMBS_WAIT: begin
                state_nxt = wait_done ? EMBS_READY : EMBS_WAIT;
            end
            EMBS_READY: begin
                state_nxt = ready ? EMBS_FINISH : EMBS_READY;
            end
            EMBS_FINISH: begin
                state_nxt = EMBS_IDLE;
            end
            default: begin
                state_nxt = EMBS_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            state_r <= EMBS_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // read data captured on the ready-high sample
    always_ff @(posedge mclk) begin
        if (reset) begin
            rdata_r <= '0;
            rsp_r   <= 1'b0;
        end else begin
            rsp_r <= (state_r == EMBS_READY) && ready;
            if ((state_r == EMBS_READY) && ready && !write_r) begin
                rdata_r <= ext_data_in;
            end
        end
    end

    logic busy;
    assign busy = (state_r == EMBS_WAIT) || (state_r == EMBS_READY);

    assign access_active_strobe_n = !busy;
    assign read_strobe_n          = !(busy && !write_r);
    assign write_enable_n         = !(busy && write_r);
    assign read_not_write         = !write_r;
    assign program_space_select_n = !(busy && space_r == SPACE_PROG);
    assign data_space_select_n    = !(busy && space_r == SPACE_DATA);
    assign io_space_select_n      = !(busy && space_r == SPACE_IO);
    assign ext_addr               = addr_r;
    assign ext_data_out           = wdata_r;
    assign ext_data_oe            = busy && write_r;
    assign cpu_stall              = busy || (state_r == EMBS_FINISH);
    assign req_ready              = (state_r == EMBS_IDLE);
    assign rsp_valid              = rsp_r;
    assign rsp_rdata              = rdata_r;
    assign wait_state_config      = wait_state_config_reg_r;

    // helper: busy delayed by one cycle, for the direction check
    logic busy_q;
    always_ff @(posedge mclk) begin
        if (reset) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= busy;
        end
    end

    strobes_exclusive_a: assert property (@(posedge mclk) disable iff (reset)
        !(!read_strobe_n && !write_enable_n)) else $error("read and write strobes together");
    read_strobe_a: assert property (@(posedge mclk) disable iff (reset)
        !read_strobe_n |-> (read_not_write && !access_active_strobe_n)) else $error("read strobe bad");
    write_enable_a: assert property (@(posedge mclk) disable iff (reset)
        !write_enable_n |-> (!read_not_write && ext_data_oe)) else $error("write enable bad");
    strobe_span_a: assert property (@(posedge mclk) disable iff (reset)
        start |=> !access_active_strobe_n) else $error("access strobe missing");
    ready_hold_a: assert property (@(posedge mclk) disable iff (reset)
        (state_r == EMBS_READY && !ready) |=> (state_r == EMBS_READY && !access_active_strobe_n))
        else $error("ready low not honoured");
    stall_until_a: assert property (@(posedge mclk) disable iff (reset)
        (state_r == EMBS_READY && ready) |=> (state_r == EMBS_FINISH && cpu_stall ##1 !cpu_stall))
        else $error("stall release wrong");
    zero_wait_a: assert property (@(posedge mclk) disable iff (reset)
        (start && wait_sel == '0) |=> (state_r == EMBS_WAIT) ##1 (state_r == EMBS_READY))
        else $error("zero wait length wrong");
    one_wait_a: assert property (@(posedge mclk) disable iff (reset)
        (start && wait_sel == WAIT_BITS'(1)) |=> (state_r == EMBS_WAIT)[*2] ##1 (state_r == EMBS_READY))
        else $error("one wait length wrong");
    config_write_a: assert property (@(posedge mclk) disable iff (reset)
        (cfg_hit && state_r == EMBS_IDLE) |=> (wait_state_config == $past(req_wdata) && access_active_strobe_n))
        else $error("config write wrong");
    prog_select_a: assert property (@(posedge mclk) disable iff (reset)
        (start && req_space == SPACE_PROG) |=> !program_space_select_n) else $error("program select missing");
    high_field_a: assert property (@(posedge mclk) disable iff (reset)
        (start && req_space == SPACE_PROG && req_addr[PROG_SPLIT_BIT]
            && wait_state_config_reg_r[HIGH_PROG_POS +: WAIT_BITS] == WAIT_BITS'(2))
        |=> (state_r == EMBS_WAIT)[*3] ##1 (state_r == EMBS_READY)) else $error("program field wrong");
    direction_a: assert property (@(posedge mclk) disable iff (reset)
        busy_q && busy |-> $stable(read_not_write)) else $error("direction changed mid access");
endmodule

// >>> embs_ext_mem.sv
// behavioural external memory or i/o part on the strobe bus
`timescale 1ns/1ps
module embs_ext_mem (
    input  wire logic        mclk,
    input  wire logic [3:0]  slow,
    input  wire logic [15:0] ext_addr,
    input  wire logic [15:0] ext_data_out,
    output logic [15:0]      ext_data_in,
    input  wire logic        read_strobe_n,
    input  wire logic        write_enable_n,
    input  wire logic        access_active_strobe_n,
    output logic             ready
);
    logic [15:0] mem [16];
    logic [3:0]  busy_cnt_r = 4'h0;
    logic [15:0] last_r = 16'h0000;

    initial for (int i = 0; i < 16; i++) mem[i] = 16'h5a00 + 16'(i);
    always @(posedge mclk) busy_cnt_r <= access_active_strobe_n ? 4'h0 : busy_cnt_r + 4'h1;
    // pulled up when idle, so only a slow access sees it low
    assign ready = access_active_strobe_n || (busy_cnt_r >= slow);
    always @(posedge mclk) if (!write_enable_n && ready) mem[ext_addr[3:0]] <= ext_data_out;
    always @(posedge mclk) last_r <= ext_data_in;
    // released bus toggles, stale data never looks valid
    assign ext_data_in = read_strobe_n ? ~last_r : mem[ext_addr[3:0]];
endmodule

// >>> embs_bus_ctrl_test.sv
// self-checking bench for the external bus strobe controller
`timescale 1ns/1ps
module embs_bus_ctrl_test;
    import embs_pkg::*;
    logic        mclk = 1'b0, reset = 1'b1, req_valid = 1'b0, req_write = 1'b0;
    logic [1:0]  req_space = 2'h0;
    logic [15:0] req_addr = 16'h0000, req_wdata = 16'h0000, rsp_rdata, ext_addr, ext_data_out;
    logic [15:0] ext_data_in, wait_state_config, rd;
    logic        req_ready, rsp_valid, cpu_stall, ext_data_oe, read_strobe_n, write_enable_n, ready;
    logic        access_active_strobe_n, read_not_write, program_space_select_n;
    logic        data_space_select_n, io_space_select_n;
    logic [3:0]  slow = 4'h0;
    int          num_errors = 0, checked = 0;

    embs_bus_ctrl dut (.mclk(mclk), .reset(reset), .req_valid(req_valid), .req_write(req_write),
        .req_space(req_space), .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .cpu_stall(cpu_stall), .ext_addr(ext_addr),
        .ext_data_out(ext_data_out), .ext_data_oe(ext_data_oe), .ext_data_in(ext_data_in),
        .read_strobe_n(read_strobe_n), .write_enable_n(write_enable_n),
        .access_active_strobe_n(access_active_strobe_n), .read_not_write(read_not_write),
        .program_space_select_n(program_space_select_n), .data_space_select_n(data_space_select_n),
        .io_space_select_n(io_space_select_n), .ready(ready), .wait_state_config(wait_state_config));
    embs_ext_mem mem_model (.mclk(mclk), .slow(slow), .ext_addr(ext_addr), .ext_data_out(ext_data_out),
        .ext_data_in(ext_data_in), .read_strobe_n(read_strobe_n), .write_enable_n(write_enable_n),
        .access_active_strobe_n(access_active_strobe_n), .ready(ready));

    initial forever #12.5 mclk = ~mclk;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // request held until taken on an idle edge
    task automatic send(input logic wr, input logic [1:0] sp, input logic [15:0] ad, input logic [15:0] wd);
        req_write = wr;
        req_space = sp;
        req_addr = ad;
        req_wdata = wd;
        req_valid = 1'b1;
        while (!req_ready) begin
            @(posedge mclk);
            #1;
        end
        @(posedge mclk);
        #1;
        req_valid = 1'b0;
    endtask

    task automatic access(input logic wr, input logic [1:0] sp, input logic [15:0] ad, input logic [15:0] wd,
                          input int exp_n);
        int n, act, str, stl, bad;
        n = 0; act = 0; str = 0; stl = 0; bad = 0;
        send(wr, sp, ad, wd);
        while (!rsp_valid && n < 40) begin
            act += !access_active_strobe_n;
            str += wr ? !write_enable_n : !read_strobe_n;
            stl += cpu_stall;
            if (!access_active_strobe_n)
                bad += (read_strobe_n === write_enable_n) || (read_not_write !== !wr) ||
                    ({program_space_select_n, data_space_select_n, io_space_select_n} !== ~(3'b100 >> sp));
            @(posedge mclk);
            #1;
            n++;
        end
        rd = rsp_rdata;
        // loop starts one cycle after the take edge, which counts as cycle zero
        chk(16'(n + 1), 16'(exp_n));
        chk(16'(act), 16'(exp_n - 1));
        chk(16'(str), 16'(exp_n - 1));
        chk(16'(stl), 16'(exp_n - 1));
        chk(16'(bad), 16'h0000);
        @(posedge mclk);
        #1;
        chk({15'h0000, cpu_stall}, 16'h0000);
    endtask

    task automatic cfg(input logic [15:0] v);
        int hit;
        hit = 0;
        send(1'b1, SPACE_IO, WSCFG_ADDR, v);
        repeat (3) begin
            hit += !access_active_strobe_n || rsp_valid;
            @(posedge mclk);
            #1;
        end
        chk(16'(hit), 16'h0000);
        chk(wait_state_config, v);
    endtask

    task automatic t_reset();
        chk(wait_state_config, WSCFG_RESET);
        chk({6'h00, read_strobe_n, write_enable_n, access_active_strobe_n, program_space_select_n,
             data_space_select_n, io_space_select_n, req_ready, cpu_stall, rsp_valid, read_not_write},
            16'h03f9);
        access(1'b0, SPACE_PROG, 16'h0003, 16'h0000, 10);
        chk(rd, 16'h5a03);
        $display("test reset done");
    endtask

    // every space and both program halves with its own field
    task automatic t_spaces();
        logic [1:0]  sp [4] = '{SPACE_PROG, SPACE_PROG, SPACE_DATA, SPACE_IO};
        logic [15:0] ad [4] = '{16'h7fff, 16'h8000, 16'h0011, 16'h0022};
        cfg(16'h08d1);
        for (int i = 0; i < 4; i++) begin
            access(1'b1, sp[i], ad[i], 16'hc000 + 16'(i), 4 + i);
            access(1'b0, sp[i], ad[i], 16'h0000, 4 + i);
            chk(rd, 16'hc000 + 16'(i));
        end
        $display("test spaces done");
    endtask

    // ready low only counts once generated waits have run out
    task automatic t_ready();
        cfg(16'h0000);
        slow = 4'h4;
        access(1'b0, SPACE_DATA, 16'h0005, 16'h0000, 6);
        chk(rd, 16'h5a05);
        cfg(16'h0249);
        slow = 4'h1;
        access(1'b0, SPACE_IO, 16'h0006, 16'h0000, 4);
        slow = 4'h3;
        access(1'b1, SPACE_PROG, 16'h0007, 16'h1234, 5);
        slow = 4'h0;
        access(1'b0, SPACE_PROG, 16'h0007, 16'h0000, 4);
        chk(rd, 16'h1234);
        $display("test ready done");
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge mclk);
        #1;
        reset = 1'b0;
        t_reset();
        t_spaces();
        t_ready();
        end_of_test();
    end

    initial begin
        #(25 * 3000);
        num_errors++;
        end_of_test();
    end
endmodule
